// ==== logic/pfwc_host.v ====
// host controller that drives a paged parallel flash over its pins
// assumes one 40 MHz clock and flash pins synchronous to it
// Summary of operation
// R1 - reads: select and output enable low, write strobe high, flash drives data
// R2 - flash floats data while select or output enable is high
// R3 - byte load: write strobe pulsed low, select low, output enable high
// R4 - flash latches address on later falling strobe edge; address set before it
// R5 - flash latches data on first rising edge; data held through it
// R6 - programming is by whole 64-byte pages
// R7 - host loads every byte of a page it changes
// R8 - next load starts within 150 us of previous rising edge
// R9 - flash programs after 150 us without a new falling edge
// R10 - page bits valid at each falling edge; byte order free
// R11 - during program cycle reads return polling status
// R12 - write lock enabled by three timed command loads
// R13 - with lock on, each page program is preceded by the three commands
// R14 - lock is nonvolatile until the disable sequence
// R15 - lock is off as delivered
// R16 - locked write without prefix only starts timer, stores nothing
// R17 - no program while output enable low, select or strobe high
// R18 - strobe pulses under 15 ns ignored
// R19 - programming blocked for 5 ms after power up
// R20 - while busy, reading last byte returns inverted bit 7
// R21 - while busy, toggle bit flips on each read
// R22 - whole-array erase by a six byte command
// R23 - program cycle time is a parameter; polling follows it
`timescale 1ns/1ps
`include "pfwc_defines.vh"
module pfwc_host #(
    parameter PWRUP_CYC = (`PFWC_PWRUP_MS * 1000000) / `PFWC_CLK_NS,
    parameter POLL_LIMIT = 16'd40000
) (
    input wire clk_i,
    input wire arst_n_i,
    // command port
    input wire cmd_valid_i,
    input wire [1:0] cmd_op_i,
    input wire [14:0] cmd_addr_i,
    input wire cmd_lock_i,
    input wire [7:0] wr_data_i,
    output reg wr_next_o,
    output reg cmd_ready_o,
    output reg done_o,
    output reg timeout_o,
    output reg [7:0] rd_data_o,
    // flash pins
    output reg chip_select_n_o,
    output reg output_enable_n_o,
    output reg write_strobe_n_o,
    output reg [14:0] addr_o,
    output reg [7:0] data_o,
    output reg data_oe_o,
    input wire [7:0] data_i
);
    localparam OP_READ = 2'd0;
    localparam OP_PAGE = 2'd1;
    localparam OP_LOCK = 2'd2;
    localparam OP_ERASE = 2'd3;
    localparam S_PWR = 4'd0;
    localparam S_IDLE = 4'd1;
    localparam S_SETUP = 4'd2;
    localparam S_WLOW = 4'd3;
    localparam S_WHIGH = 4'd4;
    localparam S_RD = 4'd5;
    localparam S_RDEND = 4'd6;
    localparam S_POLL = 4'd7;
    localparam S_POLLEND = 4'd8;
    localparam S_FIN = 4'd9;

    function [23:0] ns2cyc;
        input integer ns;
        integer cyc;
        begin
            cyc = (ns + `PFWC_CLK_NS - 1) / `PFWC_CLK_NS;
            ns2cyc = cyc[23:0];
        end
    endfunction

    localparam [31:0] WP_CYC = (`PFWC_WP_NS + `PFWC_CLK_NS - 1) / `PFWC_CLK_NS;
    localparam [31:0] GAP_CYC = (`PFWC_LOAD_GAP_US * 1000) / `PFWC_CLK_NS;
    localparam [31:0] PWRUP_W = PWRUP_CYC;

    // command byte table: 3-byte prefix, or 6-byte erase or lock off
    function [22:0] seq_entry;
        input [1:0] op;
        input [2:0] idx;
        input lock;
        begin
            case (idx)
                3'd0: seq_entry = {`PFWC_CMD_A0, `PFWC_CMD_D0};
                3'd1: seq_entry = {`PFWC_CMD_A1, `PFWC_CMD_D1};
                3'd2: seq_entry = {`PFWC_CMD_A0, (op == OP_ERASE) ? `PFWC_CMD_ER_PRE :
                    ((op == OP_LOCK && !lock) ? `PFWC_CMD_ER_PRE : `PFWC_CMD_EN)};
                3'd3: seq_entry = {`PFWC_CMD_A0, `PFWC_CMD_D0};
                3'd4: seq_entry = {`PFWC_CMD_A1, `PFWC_CMD_D1};
                default: seq_entry = {`PFWC_CMD_A0,
                    (op == OP_ERASE) ? `PFWC_CMD_ER : `PFWC_CMD_DIS};
            endcase
        end
    endfunction

    reg [3:0] state_q;
    reg [1:0] op_q;
    reg lock_q;
    reg [14:0] base_q;
    reg [2:0] pre_len_q;
    reg [2:0] pre_idx_q;
    reg [6:0] byte_q;
    reg [7:0] last_q;
    reg [15:0] polls_q;
    reg [7:0] prev_q;
    reg t_load;
    reg [23:0] t_cnt;
    wire t_busy;
    wire t_done;
    wire [22:0] ent = seq_entry(op_q, pre_idx_q, lock_q);
    wire in_pre = pre_idx_q < pre_len_q;

    pfwc_cycle_timer #(.W(24)) u_tmr (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .load_i(t_load),
        .count_i(t_cnt),
        .busy_o(t_busy),
        .done_o(t_done)
    );

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_q <= S_PWR;
            op_q <= OP_READ;
            lock_q <= 1'b0;
            base_q <= 15'h0000;
            pre_len_q <= 3'd0;
            pre_idx_q <= 3'd0;
            byte_q <= 7'd0;
            last_q <= 8'h00;
            polls_q <= 16'h0000;
            prev_q <= 8'h00;
            t_load <= 1'b0;
            t_cnt <= 24'h000000;
            wr_next_o <= 1'b0;
            cmd_ready_o <= 1'b0;
            done_o <= 1'b0;
            timeout_o <= 1'b0;
            rd_data_o <= 8'h00;
            chip_select_n_o <= 1'b1;
            output_enable_n_o <= 1'b1;
            write_strobe_n_o <= 1'b1;
            addr_o <= 15'h0000;
            data_o <= 8'h00;
            data_oe_o <= 1'b0;
        end
        else
        begin
            t_load <= 1'b0;
            wr_next_o <= 1'b0;
            done_o <= 1'b0;
            case (state_q)
                S_PWR:
                begin
                    if (!t_busy && !t_done && !t_load)
                    begin
                        // hold off all loads for the power-on delay
                        t_cnt <= PWRUP_W[23:0]; // see R19
                        t_load <= 1'b1;
                    end
                    if (t_done)
                    begin
                        state_q <= S_IDLE;
                        cmd_ready_o <= 1'b1;
                    end
                end
                S_IDLE:
                begin
                    if (cmd_valid_i)
                    begin
                        cmd_ready_o <= 1'b0;
                        timeout_o <= 1'b0;
                        op_q <= cmd_op_i;
                        lock_q <= cmd_lock_i;
                        // page bits only; byte index is counted
                        base_q <= {cmd_addr_i[14:6], 6'h00}; // see R10
                        pre_idx_q <= 3'd0;
                        byte_q <= 7'd0;
                        polls_q <= 16'h0000;
                        chip_select_n_o <= 1'b0;
                        // prefix when locked; lock on = 3, off = 6, erase = 6
                        if (cmd_op_i == OP_READ)
                            pre_len_q <= 3'd0;
                        else if (cmd_op_i == OP_PAGE)
                            pre_len_q <= cmd_lock_i ? 3'd3 : 3'd0; // see R13
                        else if (cmd_op_i == OP_LOCK && cmd_lock_i)
                            pre_len_q <= 3'd3; // see R12
                        else
                            pre_len_q <= 3'd6; // see R22
                        if (cmd_op_i == OP_READ)
                        begin
                            addr_o <= cmd_addr_i;
                            output_enable_n_o <= 1'b0; // see R1
                            data_oe_o <= 1'b0; // see R2
                            t_cnt <= ns2cyc(`PFWC_RD_NS);
                            t_load <= 1'b1;
                            state_q <= S_RD;
                        end
                        else
                        begin
                            output_enable_n_o <= 1'b1; // see R17
                            t_cnt <= ns2cyc(`PFWC_SETUP_NS);
                            t_load <= 1'b1;
                            state_q <= S_SETUP;
                        end
                    end
                end
                S_SETUP:
                begin
                    // address and data placed before the falling edge
                    if (in_pre)
                    begin
                        addr_o <= ent[22:8];
                        data_o <= ent[7:0];
                    end
                    else
                    begin
                        addr_o <= base_q | {9'h000, byte_q[5:0]}; // see R4
                        data_o <= wr_data_i;
                    end
                    data_oe_o <= 1'b1;
                    if (t_done)
                    begin
                        if (!in_pre)
                        begin
                            wr_next_o <= 1'b1;
                            last_q <= wr_data_i;
                        end
                        write_strobe_n_o <= 1'b0; // see R3
                        t_cnt <= WP_CYC[23:0]; // see R18
                        t_load <= 1'b1;
                        state_q <= S_WLOW;
                    end
                end
                S_WLOW:
                begin
                    if (t_done)
                    begin
                        // data stays driven across the rising edge
                        write_strobe_n_o <= 1'b1; // see R5
                        if (in_pre)
                            pre_idx_q <= pre_idx_q + 3'd1;
                        else
                            byte_q <= byte_q + 7'd1;
                        t_cnt <= ns2cyc(`PFWC_WPH_NS);
                        t_load <= 1'b1;
                        state_q <= S_WHIGH;
                    end
                end
                S_WHIGH:
                begin
                    if (t_done)
                    begin
                        data_oe_o <= 1'b0;
                        if (in_pre || (op_q == OP_PAGE &&
                            byte_q != `PFWC_PAGE_BYTES)) // see R6 see R7
                        begin
                            t_cnt <= ns2cyc(`PFWC_SETUP_NS); // see R8
                            t_load <= 1'b1;
                            state_q <= S_SETUP;
                        end
                        else
                        begin
                            // wait out the load window before polling
                            chip_select_n_o <= 1'b1;
                            t_cnt <= GAP_CYC[23:0] + GAP_CYC[23:0]; // see R9
                            t_load <= 1'b1;
                            state_q <= S_POLL;
                        end
                    end
                end
                S_RD:
                begin
                    if (t_done)
                    begin
                        rd_data_o <= data_i;
                        // keep the previous poll so the toggle bit can be compared
                        prev_q <= rd_data_o;
                        output_enable_n_o <= 1'b1;
                        t_cnt <= ns2cyc(`PFWC_SETUP_NS);
                        t_load <= 1'b1;
                        state_q <= (op_q == OP_READ) ? S_RDEND : S_POLLEND;
                    end
                end
                S_RDEND:
                begin
                    if (t_done)
                    begin
                        chip_select_n_o <= 1'b1;
                        state_q <= S_FIN;
                    end
                end
                S_POLL:
                begin
                    if (t_done)
                    begin
                        // poll the last loaded location
                        chip_select_n_o <= 1'b0;
                        output_enable_n_o <= 1'b0; // see R11
                        if (op_q == OP_PAGE)
                            addr_o <= base_q | {9'h000, (byte_q[5:0] - 6'd1)};
                        t_cnt <= ns2cyc(`PFWC_RD_NS);
                        t_load <= 1'b1;
                        polls_q <= polls_q + 16'h0001;
                        state_q <= S_RD;
                    end
                end
                S_POLLEND:
                begin
                    if (t_done)
                    begin
                        chip_select_n_o <= 1'b1;
                        // done when toggle bit steady on two reads and, for a page with cmd_lock_i unchanged, bit 7 matching the last loaded byte
                        if (polls_q > 16'h0001 &&
                            prev_q[`PFWC_TOG_BIT] == rd_data_o[`PFWC_TOG_BIT] &&
                            (op_q != OP_PAGE || lock_q != cmd_lock_i ||
                            rd_data_o[`PFWC_POLL_BIT] == last_q[`PFWC_POLL_BIT]))
                            state_q <= S_FIN; // see R20 see R21 see R23
                        else if (polls_q >= POLL_LIMIT)
                        begin
                            timeout_o <= 1'b1;
                            state_q <= S_FIN;
                        end
                        else
                        begin
                            t_cnt <= ns2cyc(`PFWC_SETUP_NS);
                            t_load <= 1'b1;
                            state_q <= S_POLL;
                        end
                    end
                end
                S_FIN:
                begin
                    // lock state in the flash persists; host only reports
                    done_o <= 1'b1; // see R14 see R15 see R16
                    cmd_ready_o <= 1'b1;
                    state_q <= S_IDLE;
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end
endmodule // pfwc_host

// ==== logic/pfwc_defines.vh ====
// constants for the paged flash host controller
// assumes a 40 MHz controller clock; times below are in ns, us or ms
`ifndef PFWC_DEFINES_VH
`define PFWC_DEFINES_VH
`define PFWC_CLK_NS 25
// byte loads: strobe low and high phases; pulse kept well above the noise filter
`define PFWC_GLITCH_NS 15
`define PFWC_WP_NS 100
`define PFWC_WPH_NS 50
`define PFWC_SETUP_NS 25
// load window; host waits twice the gap constant, past the window, before polling
`define PFWC_LOAD_WIN_US 150
`define PFWC_LOAD_GAP_US 100
`define PFWC_PWRUP_MS 5
`define PFWC_RD_NS 200
// write lock and erase command codes
`define PFWC_CMD_A0 15'h5555
`define PFWC_CMD_A1 15'h2AAA
`define PFWC_CMD_D0 8'hAA
`define PFWC_CMD_D1 8'h55
`define PFWC_CMD_EN 8'hA0
`define PFWC_CMD_DIS 8'h20
`define PFWC_CMD_ER 8'h10
`define PFWC_CMD_ER_PRE 8'h80
`define PFWC_PAGE_BYTES 64
`define PFWC_POLL_BIT 7
`define PFWC_TOG_BIT 6
`endif

// ==== logic/pfwc_cycle_timer.v ====
// one-shot cycle counter used for strobe phases and waits
// assumes load_i is a one-cycle pulse; done_o pulses when the count ends
`timescale 1ns/1ps
module pfwc_cycle_timer #(
    parameter W = 24
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire load_i,
    input wire [W-1:0] count_i,
    output reg busy_o,
    output reg done_o
);
    reg [W-1:0] cnt_q;
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_q <= {W{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (load_i)
            begin
                cnt_q <= count_i;
                busy_o <= 1'b1;
            end
            else if (busy_o)
            begin
                if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
                begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                else
                    cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // pfwc_cycle_timer

// ==== testbench/pfwc_host_monitor.sv ====
// pin-level checker for the flash host controller
// assumes a bind onto pfwc_host; one clock domain, async active-low reset
`timescale 1ns/1ps
module pfwc_host_monitor (
    input wire clk_i,
    input wire arst_n_i,
    input wire cmd_ready_o,
    input wire done_o,
    input wire chip_select_n_o,
    input wire output_enable_n_o,
    input wire write_strobe_n_o,
    input wire [14:0] addr_o,
    input wire [7:0] data_o,
    input wire data_oe_o
);
    // 150 us at 40 MHz
    localparam int LOAD_WIN_CYC = 6000;
    reg we_prev_q;
    reg seen_q;
    reg [15:0] gap_q;
    wire we_rise = write_strobe_n_o && !we_prev_q;
    // gap only matters between loads of one command
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            we_prev_q <= 1'b1;
            seen_q <= 1'b0;
            gap_q <= 16'h0000;
        end
        else
        begin
            we_prev_q <= write_strobe_n_o;
            seen_q <= done_o ? 1'b0 : (seen_q | we_rise);
            if (we_rise)
                gap_q <= 16'h0000;
            else if (gap_q != 16'hFFFF)
                gap_q <= gap_q + 16'h0001;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    chk_load_oe_high: assert property ($fell(write_strobe_n_o) |->
        output_enable_n_o && !chip_select_n_o) else $error("strobe fell without load pins");
    chk_load_pins_hold: assert property (!write_strobe_n_o && !$fell(write_strobe_n_o) |->
        $stable(addr_o) && $stable(data_o)) else $error("address or data moved in load");
    chk_data_at_rise: assert property ($rose(write_strobe_n_o) |->
        data_oe_o && $stable(data_o) && $stable(addr_o)) else $error("data not held at rise");
    chk_strobe_width: assert property ($fell(write_strobe_n_o) |=>
        !write_strobe_n_o [*3]) else $error("strobe pulse too short");
    chk_read_no_drive: assert property (!output_enable_n_o |->
        !data_oe_o && write_strobe_n_o) else $error("host drives data during read");
    chk_load_gap: assert property ($fell(write_strobe_n_o) && seen_q |->
        gap_q < LOAD_WIN_CYC) else $error("load gap over window");
    chk_done_pulse: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
    chk_idle_pins: assert property (cmd_ready_o |->
        chip_select_n_o && write_strobe_n_o) else $error("pins active while idle");
    cover property ($fell(write_strobe_n_o));
    cover property ($fell(output_enable_n_o));
    cover property (done_o);
endmodule // pfwc_host_monitor

bind pfwc_host pfwc_host_monitor u_pfwc_host_monitor (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .chip_select_n_o(chip_select_n_o),
    .output_enable_n_o(output_enable_n_o), .write_strobe_n_o(write_strobe_n_o),
    .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o));

// ==== testbench/pfwc_flash_model.sv ====
// behavioural paged flash device driven by the host controller
// assumes pins come from a synchronous host; times are in ns
`timescale 1ns/1ps
`include "pfwc_defines.vh"
module pfwc_flash_model #(
    parameter TWC_NS = 100000,
    parameter PWRUP_NS = 400,
    parameter WIN_NS = 150000,
    parameter GLITCH_NS = 15
) (
    input wire ce_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire [14:0] addr_i,
    input wire [7:0] dq_i,
    output wire [7:0] dq_o,
    output wire dq_oe_o
);
    reg [7:0] mem [0:32767];
    reg lock_q = 1'b0;
    reg busy_q = 1'b0;
    reg tog_q = 1'b0;
    reg [7:0] last_q = 8'hFF;
    reg [14:0] la_q;
    reg [14:0] ladr [0:69];
    reg [7:0] ldat [0:69];
    realtime t_fall = 0.0;
    realtime t_rise = 0.0;
    integer n = 0;
    integer i;
    wire wr = !ce_n_i && !we_n_i && oe_n_i;
    wire rd = !ce_n_i && !oe_n_i && we_n_i;
    assign dq_oe_o = rd;
    assign dq_o = busy_q ? {~last_q[7], tog_q, last_q[5:0]} : mem[addr_i];
    initial for (i = 0; i < 32768; i = i + 1) mem[i] = 8'hFF;
    always @(posedge rd) if (busy_q) tog_q <= ~tog_q;
    always @(posedge wr)
    begin
        la_q = addr_i;
        t_fall = $realtime;
    end
    // short pulses, early power-up and loads while busy are dropped
    always @(negedge wr)
        if ($realtime - t_fall >= GLITCH_NS && $realtime >= PWRUP_NS && !busy_q && n < 70)
        begin
            ladr[n] = la_q;
            ldat[n] = dq_i;
            n = n + 1;
            t_rise = $realtime;
        end
    function hit(input integer k, input [14:0] a, input [7:0] d);
        hit = (ladr[k] === a) && (ldat[k] === d);
    endfunction
    task close_load;
        integer s;
        integer k;
        reg [63:0] got;
        reg [8:0] pg;
        reg pre;
        begin
            s = 0;
            got = 64'h0;
            pre = n >= 3 && hit(0, `PFWC_CMD_A0, `PFWC_CMD_D0) && hit(1, `PFWC_CMD_A1, `PFWC_CMD_D1);
            if (pre && hit(2, `PFWC_CMD_A0, `PFWC_CMD_EN))
            begin
                lock_q = 1'b1;
                s = 3;
            end
            else if (pre && n >= 6 && hit(2, `PFWC_CMD_A0, `PFWC_CMD_ER_PRE)
                && hit(3, `PFWC_CMD_A0, `PFWC_CMD_D0) && hit(4, `PFWC_CMD_A1, `PFWC_CMD_D1))
            begin
                s = 6;
                if (hit(5, `PFWC_CMD_A0, `PFWC_CMD_DIS)) lock_q = 1'b0;
                if (hit(5, `PFWC_CMD_A0, `PFWC_CMD_ER))
                    for (k = 0; k < 32768; k = k + 1) mem[k] = 8'hFF;
            end
            if (n > s && !(s == 0 && lock_q))
            begin
                pg = ladr[n-1][14:6];
                for (k = s; k < n; k = k + 1)
                begin
                    mem[{pg, ladr[k][5:0]}] = ldat[k];
                    got[ladr[k][5:0]] = 1'b1;
                end
                for (k = 0; k < 64; k = k + 1)
                    if (!got[k]) mem[{pg, k[5:0]}] = ~mem[{pg, k[5:0]}];
            end
            last_q = ldat[n-1];
            n = 0;
            busy_q = 1'b1;
            #(TWC_NS) busy_q = 1'b0;
        end
    endtask
    always
    begin
        #100;
        if (n > 0 && !wr && $realtime - t_rise >= WIN_NS) close_load;
    end
endmodule // pfwc_flash_model

// ==== testbench/pfwc_host_tb_top.sv ====
// self-checking bench: host controller against the flash model
// assumes 40 MHz clock; power-up count shortened to 20 cycles
`timescale 1ns/1ps
module pfwc_host_tb_top;
    reg clk_i = 1'b0;
    reg arst_n_i = 1'b0;
    reg cmd_valid_i = 1'b0;
    reg [1:0] cmd_op_i = 2'h0;
    reg [14:0] cmd_addr_i = 15'h0000;
    reg cmd_lock_i = 1'b0;
    reg [7:0] pat_q = 8'h00;
    reg [7:0] idx_q = 8'h00;
    reg [7:0] float_q = 8'h5A;
    integer err_total = 0;
    integer checked = 0;
    wire [7:0] wr_data_i = pat_q + idx_q;
    wire wr_next_o, cmd_ready_o, done_o, timeout_o, ce_n, oe_n, we_n, data_oe_o, fl_oe;
    wire [7:0] rd_data_o, data_o, fl_dq;
    wire [14:0] addr_o;
    // a released bus keeps changing so stale data cannot pass
    wire [7:0] dq_bus = data_oe_o ? data_o : (fl_oe ? fl_dq : float_q);
    pfwc_host #(.PWRUP_CYC(20), .POLL_LIMIT(16'd400)) u_pfwc_host (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
        .cmd_addr_i(cmd_addr_i), .cmd_lock_i(cmd_lock_i), .wr_data_i(wr_data_i),
        .wr_next_o(wr_next_o), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
        .timeout_o(timeout_o), .rd_data_o(rd_data_o), .chip_select_n_o(ce_n),
        .output_enable_n_o(oe_n), .write_strobe_n_o(we_n), .addr_o(addr_o),
        .data_o(data_o), .data_oe_o(data_oe_o), .data_i(dq_bus));
    pfwc_flash_model u_pfwc_flash_model (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .addr_i(addr_o), .dq_i(dq_bus), .dq_o(fl_dq), .dq_oe_o(fl_oe));
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        float_q <= ~float_q;
        // byte index restarts as each command is taken
        if (cmd_valid_i)
            idx_q <= 8'h00;
        else if (wr_next_o === 1'b1)
            idx_q <= idx_q + 8'h01;
    end
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp)
            begin
                err_total = err_total + 1;
                $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task do_cmd(input [1:0] op, input [14:0] a, input lk, input [7:0] pat);
        integer w;
        begin
            pat_q = pat;
            cmd_op_i = op;
            cmd_addr_i = a;
            cmd_lock_i = lk;
            w = 0;
            // outputs are looked at settled, just after the edge
            while (cmd_ready_o !== 1'b1 && w < 2000)
            begin
                @(posedge clk_i);
                #2 w = w + 1;
            end
            cmd_valid_i = 1'b1;
            @(posedge clk_i);
            #2 cmd_valid_i = 1'b0;
            w = 0;
            while (done_o !== 1'b1 && w < 30000)
            begin
                @(posedge clk_i);
                #2 w = w + 1;
            end
            checked = checked + 1;
            if (done_o !== 1'b1)
            begin
                err_total = err_total + 1;
                $display("[FAIL] %0t command not completed", $time);
            end
        end
    endtask
    task rd(input [14:0] a, input [7:0] exp);
        begin
            do_cmd(2'd0, a, 1'b0, 8'h00);
            chk(rd_data_o, exp);
        end
    endtask
    task t_blank;
        begin
            chk({7'h00, u_pfwc_flash_model.lock_q}, 8'h00);
            rd(15'h0000, 8'hFF);
            rd(15'h7FFF, 8'hFF);
            $display("test blank done");
        end
    endtask
    task t_prog;
        begin
            do_cmd(2'd1, 15'h00C0, 1'b0, 8'h80);
            chk({7'h00, timeout_o}, 8'h00);
            rd(15'h00C0, 8'h80);
            rd(15'h00FF, 8'hBF);
            rd(15'h0100, 8'hFF);
            $display("test page program done");
        end
    endtask
    task t_lock_on;
        begin
            do_cmd(2'd2, 15'h0000, 1'b1, 8'h00);
            chk({7'h00, u_pfwc_flash_model.lock_q}, 8'h01);
            do_cmd(2'd1, 15'h0140, 1'b1, 8'h11);
            rd(15'h0140, 8'h11);
            rd(15'h017F, 8'h50);
            $display("test lock on done");
        end
    endtask
    task t_no_prefix;
        begin
            // poll may time out here: old bit 7 never matches
            do_cmd(2'd1, 15'h00C0, 1'b0, 8'h00);
            chk({7'h00, timeout_o}, 8'h01);
            rd(15'h00C0, 8'h80);
            rd(15'h00C1, 8'h81);
            $display("test locked write done");
        end
    endtask
    task t_lock_off;
        begin
            do_cmd(2'd2, 15'h0000, 1'b0, 8'h00);
            chk({7'h00, u_pfwc_flash_model.lock_q}, 8'h00);
            do_cmd(2'd1, 15'h01C0, 1'b0, 8'h22);
            rd(15'h01C5, 8'h27);
            $display("test lock off done");
        end
    endtask
    task t_erase;
        begin
            do_cmd(2'd3, 15'h0000, 1'b0, 8'h00);
            rd(15'h00C0, 8'hFF);
            rd(15'h0140, 8'hFF);
            $display("test erase done");
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        #2 arst_n_i = 1'b1;
        t_blank;
        t_prog;
        t_lock_on;
        t_no_prefix;
        t_lock_off;
        t_erase;
        final_report;
    end
    initial
    begin
        repeat (95000) @(posedge clk_i);
        err_total = err_total + 1;
        final_report;
    end
endmodule // pfwc_host_tb_top
